// ---- dv/spsq_drive_model.sv ----
// behavioural ramp generator and motor at the sequencer's far side
`timescale 1ns/1ps
module spsq_drive_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// bench settings: step per cycle and motor slip
	input wire logic signed [15:0] step,
	input wire logic signed [15:0] slip,
	// sequencer side
	input wire logic signed [15:0] speed_ref,
	output logic signed [15:0] ramp_output,
	output logic signed [15:0] motor_speed
);
	// slew toward the reference; a small step makes a slow drive
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ramp_output <= 16'sh0000;
		end else if (speed_ref > ramp_output + step) begin
			ramp_output <= ramp_output + step;
		end else if (speed_ref < ramp_output - step) begin
			ramp_output <= ramp_output - step;
		end else begin
			ramp_output <= speed_ref;
		end
	end
	// motor trails the ramp by a fixed slip
	assign motor_speed = ramp_output + slip;
endmodule // spsq_drive_model

// ---- dv/spsq_seq_monitor.sv ----
// assertion checker for the speed sequencer top
`timescale 1ns/1ps
module spsq_seq_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// controls
	input wire logic run_cmd,
	input wire logic stop_cmd,
	input wire logic fault,
	input wire logic power_fail,
	input wire logic [11:0] program_mode_word,
	input wire logic [255:0] stage_duration_table,
	input wire logic deviation_clamp_enable,
	input wire logic signed [15:0] ramp_output,
	// observed
	input wire logic signed [15:0] ramp_cmd,
	input wire logic signed [15:0] band_upper,
	input wire logic signed [15:0] band_lower,
	input wire logic [1:0] ramp_set,
	input wire logic running,
	input wire logic program_active,
	input wire logic [3:0] stage_index,
	input wire logic cycle_done,
	input wire logic resume_pending
);
	// ==========================================================
	// one clock domain, so one default clock and disable
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire logic m0 = program_mode_word[1:0] == 2'h0;
	property p_off; m0 |=> !program_active && !running; endproperty
	a_off: assert property (p_off) else $error("program active in mode off");
	property p_start; !program_active && run_cmd && !stop_cmd && !fault && !power_fail && !m0 && !resume_pending
		&& stage_duration_table[15:0] != 16'h0000 |=> running && stage_index == 4'h0; endproperty
	a_start: assert property (p_start) else $error("run did not start at stage one");
	property p_stop; running && stop_cmd && !power_fail |=> !running; endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_power; power_fail |=> !running && !program_active; endproperty
	a_power: assert property (p_power) else $error("running through power loss");
	property p_pulse; cycle_done |=> !cycle_done; endproperty
	a_pulse: assert property (p_pulse) else $error("cycle end flag too long");
	property p_single; cycle_done && program_mode_word[1:0] == 2'h1 |-> ##[0:1] !running; endproperty
	a_single: assert property (p_single) else $error("no stop after single cycle");
	property p_loop; cycle_done && program_mode_word[1:0] == 2'h3 |-> ##[0:1] running && stage_index == 4'h0;
	endproperty
	a_loop: assert property (p_loop) else $error("loop did not restart at stage one");
	property p_idle_set; !program_active |-> ramp_set == 2'h0; endproperty
	a_idle_set: assert property (p_idle_set) else $error("ramp set while idle");
	property p_pass; !deviation_clamp_enable |=> ramp_cmd == $past(ramp_output) && band_upper == 16'sh7fff
		&& band_lower == 16'sh8000; endproperty
	a_pass: assert property (p_pass) else $error("clamp acts while disabled");
endmodule // spsq_seq_monitor
bind spsq_sequencer spsq_seq_monitor u_mon (.clk(clk), .reset_n(reset_n), .run_cmd(run_cmd),
	.stop_cmd(stop_cmd), .fault(fault), .power_fail(power_fail), .program_mode_word(program_mode_word),
	.stage_duration_table(stage_duration_table), .deviation_clamp_enable(deviation_clamp_enable),
	.ramp_output(ramp_output), .ramp_cmd(ramp_cmd), .band_upper(band_upper), .band_lower(band_lower),
	.ramp_set(ramp_set), .running(running), .program_active(program_active), .stage_index(stage_index),
	.cycle_done(cycle_done), .resume_pending(resume_pending));

// ---- dv/test_spsq_sequencer.sv ----
// self-checking testbench for the speed sequencer
`timescale 1ns/1ps
module test_spsq_sequencer;
	logic clk, reset_n, run, stop, flt, pf, ld, den, mem, running, act, cd, rp;
	logic [11:0] mode;
	logic [1:0] unit, rs;
	logic [255:0] dur, pre;
	logic [127:0] set;
	logic [63:0] skt;
	logic [15:0] maxs, el, v;
	logic [8:0] skw;
	logic [10:0] dpos;
	logic signed [11:0] dneg;
	logic signed [15:0] ext, step, slip, sref, rcmd, bu, bl, ro, ms;
	logic [3:0] idx;
	int err_count, tests_run, n;
	// ==========================================================
	// short tick period keeps stage times within a few cycles
	spsq_sequencer #(.TENTH_CYCLES(4)) u_dut (.clk(clk), .reset_n(reset_n), .run_cmd(run), .stop_cmd(stop),
		.fault(flt), .power_fail(pf), .program_mode_word(mode), .stage_time_unit_select(unit),
		.stage_duration_table(dur), .stage_setting_table(set), .preset_speed_table(pre),
		.external_speed_cmd(ext), .external_cmd_load(ld), .ramp_output(ro), .motor_speed(ms), .max_speed(maxs),
		.deviation_clamp_enable(den), .deviation_positive_limit(dpos), .deviation_negative_limit(dneg),
		.skip_speed_table(skt), .skip_band_width(skw), .speed_memory_select(mem), .speed_ref(sref),
		.ramp_cmd(rcmd), .band_upper(bu), .band_lower(bl), .ramp_set(rs), .running(running),
		.program_active(act), .stage_index(idx), .stage_elapsed(el), .cycle_done(cd), .resume_pending(rp));
	spsq_drive_model u_drive (.clk(clk), .reset_n(reset_n), .step(step), .slip(slip), .speed_ref(sref),
		.ramp_output(ro), .motor_speed(ms));
	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one-cycle pulse: 0 run, 1 stop, 2 fault, 3 load; returns after the taking edge
	task automatic hit(input int k);
		@(posedge clk);
		case (k)
			0: run <= 1'b1;
			1: stop <= 1'b1;
			2: flt <= 1'b1;
			default: ld <= 1'b1;
		endcase
		@(posedge clk);
		{run, stop, flt, ld} <= 4'h0;
		@(negedge clk);
	endtask
	task automatic pwr();
		@(posedge clk);
		pf <= 1'b1;
		repeat (3) @(posedge clk);
		pf <= 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// bounded wait for a stage; running out counts as a mismatch
	task automatic wait_for(input logic [3:0] e, input int lim);
		n = 0;
		while (idx !== e && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) begin
			err_count++;
			$display("CHECK FAILED stage wait expected %h seen %h", e, idx);
			wrap_up();
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		{reset_n, run, stop, flt, pf, ld, den, mem} = 8'h01;
		{mode, unit, skw, step, slip} = '0;
		dur = {224'h0, 16'h0003, 16'h0002};
		set = {112'h0, 8'h21, 8'h10};
		pre = {224'h0, 16'h02bc, 16'h012c};
		skt = {48'h0, 16'd500};
		{maxs, ext, dpos, dneg, step} = {16'd1000, 16'd480, 11'd50, -12'sd50, 16'd1000};
		{err_count, tests_run} = '0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(negedge clk);
		chk("boot ref", 16'd300, sref);
		hit(0);
		chk("active", 16'h0, {15'h0, act});
		skw <= 9'd100;
		hit(3);
		repeat (3) @(negedge clk);
		chk("skip low", 16'd450, sref);
		ext <= 16'sd520;
		hit(3);
		repeat (3) @(negedge clk);
		chk("skip high", 16'd550, sref);
		skw <= 9'd0;
		slip <= -16'sd200;
		den <= 1'b1;
		repeat (4) @(negedge clk);
		chk("no skip", 16'd520, sref);
		chk("clamp", 16'd370, rcmd);
		chk("band up", 16'd570, bu);
		chk("band low", 16'd470, bl);
		{den, slip, mem} <= 18'h00000;
		pwr();
		chk("memory off", 16'd300, sref);
		// single cycle walk: preset stage then external stage
		{ext, mode} <= {16'sd900, 12'h001};
		hit(3);
		hit(0);
		chk("running", 16'h1, {15'h0, running});
		chk("first set", 16'h1, {14'h0, rs});
		@(negedge clk);
		chk("first ref", 16'd300, sref);
		wait_for(4'h1, 40);
		chk("stage time", 16'h1, {15'h0, n >= 2 && n <= 8});
		repeat (2) @(negedge clk);
		chk("second set", 16'h2, {14'h0, rs});
		chk("second ref", 16'd900, sref);
		repeat (16) @(negedge clk);
		chk("stopped", 16'h0, {15'h0, running});
		mode <= 12'h003;
		hit(0);
		wait_for(4'h1, 40);
		wait_for(4'h0, 40);
		mode <= 12'h002;
		wait_for(4'h1, 40);
		repeat (20) @(negedge clk);
		chk("hold stage", 16'h1, {12'h0, idx});
		chk("hold run", 16'h1, {15'h0, running});
		chk("hold time", 16'h0003, el);
		hit(1);
		// interrupt by fault with stage resume
		mode <= 12'h013;
		hit(0);
		wait_for(4'h1, 40);
		hit(2);
		chk("saved", 16'h1, {15'h0, rp});
		hit(0);
		chk("resume stage", 16'h1, {12'h0, idx});
		mode <= 12'h003;
		hit(1);
		hit(0);
		chk("from first", 16'h0, {12'h0, idx});
		// slow drive: resume at the captured running speed
		{mode, step} <= {12'h023, 16'sd1};
		hit(1);
		hit(0);
		wait_for(4'h1, 40);
		repeat (3) @(posedge clk);
		stop <= 1'b1;
		@(negedge clk);
		v = ro;
		@(posedge clk);
		stop <= 1'b0;
		hit(0);
		repeat (2) @(negedge clk);
		chk("saved speed", v, sref);
		{mode, step} <= {12'h113, 16'sd1000};
		hit(1);
		hit(0);
		wait_for(4'h1, 40);
		pwr();
		chk("kept", 16'h1, {15'h0, rp});
		hit(0);
		chk("power resume", 16'h1, {12'h0, idx});
		mode <= 12'h013;
		pwr();
		chk("not kept", 16'h0, {15'h0, rp});
		hit(0);
		chk("power first", 16'h0, {12'h0, idx});
		// minute unit stretches stage time sixtyfold
		{unit, mode} <= {2'h1, 12'h001};
		hit(1);
		hit(0);
		wait_for(4'h1, 600);
		chk("minute time", 16'h1, {15'h0, n >= 200 && n <= 490});
		hit(1);
		// hour unit: a tenth is 3600 second tenths
		unit <= 2'h2;
		hit(0);
		wait_for(4'h1, 30000);
		chk("hour time", 16'h1, {15'h0, n >= 20000 && n <= 28900});
		hit(1);
		wrap_up();
	end
endmodule // test_spsq_sequencer

// ---- pkg/spsq_pkg.sv ----
// shared constants and types for the stage program speed sequencer
package spsq_pkg;
	// ==========================================================
	// sizes
	localparam int STAGES = 16;
	localparam int STAGE_W = 4;
	localparam int SPD_W = 16;
	localparam int DUR_W = 16;
	localparam int SETTING_W = 8;
	localparam int SKIPS = 4;
	localparam int SKIP_W_W = 9;
	localparam int PCT_W = 11;
	// ==========================================================
	// digit positions inside the mode word and the stage setting word
	localparam int UNITS_LSB = 0;
	localparam int TENS_LSB = 4;
	localparam int HUNDREDS_LSB = 8;
	// ==========================================================
	// program mode codes (units digit)
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ONE_STOP = 2'h1;
	localparam logic [1:0] MODE_ONE_HOLD = 2'h2;
	localparam logic [1:0] MODE_LOOP = 2'h3;
	// restart codes (tens digit)
	localparam logic [1:0] RESTART_FIRST = 2'h0;
	localparam logic [1:0] RESTART_STAGE_FREQ = 2'h1;
	localparam logic [1:0] RESTART_RUN_FREQ = 2'h2;
	// power-down storage codes (hundreds digit)
	localparam logic STORE_NONE = 1'h0;
	localparam logic STORE_KEEP = 1'h1;
	// time unit codes
	localparam logic [1:0] UNIT_SEC = 2'h0;
	localparam logic [1:0] UNIT_MIN = 2'h1;
	localparam logic [1:0] UNIT_HOUR = 2'h2;
	// speed source codes (units digit of a stage setting)
	localparam logic [1:0] SRC_PRESET = 2'h0;
	localparam logic [1:0] SRC_EXTERNAL = 2'h1;
	// ==========================================================
	// reset values
	localparam logic [DUR_W-1:0] DUR_RESET = 16'h0000;
	localparam logic [DUR_W-1:0] DUR_MAX = 16'h8ca0; // 3600.0 in tenths
	localparam logic [PCT_W-1:0] DEV_POS_RESET = 11'h032; // 5.0 % in tenths
	localparam logic signed [PCT_W:0] DEV_NEG_RESET = -12'sh032; // -5.0 %
	localparam logic MEMORY_RESET = 1'h1;
	localparam int PCT_FULL = 1000; // 100.0 % in tenths
	// ==========================================================
	// timing: durations count in tenths of the chosen unit
	localparam int CLK_PERIOD_NS = 10;
	localparam int TENTH_SEC_NS = 100000000;
	localparam int TENTH_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;
	localparam int SEC_PER_MIN = 60;
	localparam int SEC_PER_HOUR = 3600;
	// ==========================================================
	// sequencer states
	typedef enum logic [1:0] {st_idle, st_run, st_hold} spsq_state_t;
endpackage

// ---- verilog/spsq_sequencer.sv ----
// stage program speed sequencer top: stage stepping, restart, retention, memory
`timescale 1ns/1ps
module spsq_sequencer #(
	parameter int STAGES = spsq_pkg::STAGES,
	parameter int SPD_W = spsq_pkg::SPD_W,
	parameter int DUR_W = spsq_pkg::DUR_W,
	parameter int SKIPS = spsq_pkg::SKIPS,
	parameter int TENTH_CYCLES = spsq_pkg::TENTH_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// run control from the command source (same clock)
	input wire logic run_cmd,
	input wire logic stop_cmd,
	input wire logic fault,
	input wire logic power_fail,
	// program configuration
	input wire logic [11:0] program_mode_word,
	input wire logic [1:0] stage_time_unit_select,
	input wire logic [STAGES*DUR_W-1:0] stage_duration_table,
	input wire logic [STAGES*spsq_pkg::SETTING_W-1:0] stage_setting_table,
	input wire logic [STAGES*SPD_W-1:0] preset_speed_table,
	// speed command and feedback
	input wire logic signed [SPD_W-1:0] external_speed_cmd,
	input wire logic external_cmd_load,
	input wire logic signed [SPD_W-1:0] ramp_output,
	input wire logic signed [SPD_W-1:0] motor_speed,
	input wire logic [SPD_W-1:0] max_speed,
	// speed conditioning settings
	input wire logic deviation_clamp_enable,
	input wire logic [spsq_pkg::PCT_W-1:0] deviation_positive_limit,
	input wire logic signed [spsq_pkg::PCT_W:0] deviation_negative_limit,
	input wire logic [SKIPS*SPD_W-1:0] skip_speed_table,
	input wire logic [spsq_pkg::SKIP_W_W-1:0] skip_band_width,
	input wire logic speed_memory_select,
	// outputs to the ramp generator
	output logic signed [SPD_W-1:0] speed_ref,
	output logic signed [SPD_W-1:0] ramp_cmd,
	output logic signed [SPD_W-1:0] band_upper,
	output logic signed [SPD_W-1:0] band_lower,
	output logic [1:0] ramp_set,
	output logic running,
	// program status
	output logic program_active,
	output logic [spsq_pkg::STAGE_W-1:0] stage_index,
	output logic [DUR_W-1:0] stage_elapsed,
	output logic cycle_done,
	output logic resume_pending
);
	localparam int SW = spsq_pkg::STAGE_W;
	localparam int TW = spsq_pkg::SETTING_W;

	typedef struct packed {
		spsq_pkg::spsq_state_t fsm;
		logic [SW-1:0] stage;
		logic [DUR_W-1:0] elapsed;
		logic [SW-1:0] saved_stage;
		logic [DUR_W-1:0] saved_elapsed;
		logic signed [SPD_W-1:0] saved_freq;
		logic saved_valid;
		logic use_saved_freq;
		logic signed [SPD_W-1:0] freq_cmd;
		logic signed [SPD_W-1:0] raw_ref;
		logic [1:0] ramp_set;
		logic running;
		logic cycle_done;
		logic power_prev;
		logic boot;
	} spsq_seq_state_t;

	spsq_seq_state_t state;
	spsq_seq_state_t next_state;
	logic [1:0] mode;
	logic [1:0] restart;
	logic store;
	logic tick;
	logic tick_en;
	logic [DUR_W-1:0] dur [STAGES];
	logic [TW-1:0] setting [STAGES];
	logic signed [SPD_W-1:0] preset [STAGES];
	logic [SW-1:0] nxt_stage;
	logic last_stage;
	logic stage_done;
	logic [DUR_W-1:0] elapsed_inc;
	logic power_drop;
	logic power_back;

	// ==========================================================
	// field unpacking of the mode word and the per-stage tables
	assign mode = program_mode_word[spsq_pkg::UNITS_LSB +: 2];
	assign restart = program_mode_word[spsq_pkg::TENS_LSB +: 2];
	assign store = program_mode_word[spsq_pkg::HUNDREDS_LSB];

	genvar g;
	generate
		for (g = 0; g < STAGES; g++) begin : g_stage
			assign dur[g] = stage_duration_table[g*DUR_W +: DUR_W];
			assign setting[g] = stage_setting_table[g*TW +: TW];
			assign preset[g] = preset_speed_table[g*SPD_W +: SPD_W];
		end
	endgenerate

	// ==========================================================
	// tenth-of-unit time base, only counting while a stage runs
	assign tick_en = (state.fsm == spsq_pkg::st_run) && !power_fail;

	spsq_unit_tick #(
		.TENTH_CYCLES(TENTH_CYCLES)
	) u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.enable(tick_en),
		.unit_sel(stage_time_unit_select),
		.tick(tick)
	);

	// stage end: the timer runs from stage entry, so ramp time is counted too
	assign elapsed_inc = state.elapsed + DUR_W'(1);
	assign stage_done = tick && (elapsed_inc >= dur[state.stage]);
	assign nxt_stage = state.stage + SW'(1);
	// a zero duration marks the end of the configured program
	assign last_stage = (state.stage == SW'(STAGES - 1)) || (dur[nxt_stage] == spsq_pkg::DUR_RESET);

	assign power_drop = power_fail && !state.power_prev;
	assign power_back = !power_fail && state.power_prev;

	// ==========================================================
	// sequencer state machine; priority power loss > fault > stop > run
	always_comb begin
		next_state = state;
		next_state.power_prev = power_fail;
		next_state.cycle_done = 1'b0;
		next_state.boot = 1'b0;
		// frequency command memory: loads track the external command
		if (state.boot) begin
			next_state.freq_cmd = preset[0];
		end else if (power_back && speed_memory_select == 1'b0) begin
			next_state.freq_cmd = preset[0];
		end else if (external_cmd_load && !power_fail) begin
			next_state.freq_cmd = external_speed_cmd;
		end
		if (power_drop) begin
			next_state.fsm = spsq_pkg::st_idle;
			if (store == spsq_pkg::STORE_KEEP) begin
				if (state.fsm == spsq_pkg::st_run) begin
					next_state.saved_stage = state.stage;
					next_state.saved_elapsed = state.elapsed;
					next_state.saved_freq = ramp_output;
					next_state.saved_valid = 1'b1;
				end else if (state.fsm == spsq_pkg::st_hold) begin
					next_state.saved_valid = 1'b0;
				end
			end else begin
				next_state.saved_valid = 1'b0;
			end
		end else if (power_fail) begin
			next_state.fsm = spsq_pkg::st_idle;
		end else if (power_back && restart == spsq_pkg::RESTART_FIRST) begin
			next_state.saved_valid = 1'b0;
		end else if (mode == spsq_pkg::MODE_OFF) begin
			next_state.fsm = spsq_pkg::st_idle;
			next_state.saved_valid = 1'b0;
		end else begin
			case (state.fsm)
				spsq_pkg::st_idle: begin
					if (run_cmd && !fault && !stop_cmd) begin
						if (state.saved_valid && restart != spsq_pkg::RESTART_FIRST) begin
							next_state.fsm = spsq_pkg::st_run;
							next_state.stage = state.saved_stage;
							next_state.elapsed = state.saved_elapsed;
							next_state.use_saved_freq = (restart == spsq_pkg::RESTART_RUN_FREQ);
						end else if (dur[0] != spsq_pkg::DUR_RESET) begin
							next_state.fsm = spsq_pkg::st_run;
							next_state.stage = '0;
							next_state.elapsed = '0;
							next_state.use_saved_freq = 1'b0;
						end
						next_state.saved_valid = 1'b0;
					end
				end
				spsq_pkg::st_run: begin
					if (fault || stop_cmd) begin
						next_state.fsm = spsq_pkg::st_idle;
						next_state.saved_stage = state.stage;
						next_state.saved_elapsed = state.elapsed;
						next_state.saved_freq = ramp_output;
						next_state.saved_valid = (restart != spsq_pkg::RESTART_FIRST);
					end else if (stage_done) begin
						next_state.use_saved_freq = 1'b0;
						if (!last_stage) begin
							next_state.stage = nxt_stage;
							next_state.elapsed = '0;
						end else begin
							next_state.cycle_done = 1'b1;
							next_state.elapsed = elapsed_inc;
							case (mode)
								spsq_pkg::MODE_ONE_STOP: next_state.fsm = spsq_pkg::st_idle;
								spsq_pkg::MODE_ONE_HOLD: next_state.fsm = spsq_pkg::st_hold;
								spsq_pkg::MODE_LOOP: begin
									next_state.stage = '0;
									next_state.elapsed = '0;
								end
								default: next_state.fsm = spsq_pkg::st_idle;
							endcase
						end
					end else if (tick) begin
						next_state.elapsed = elapsed_inc;
					end
				end
				spsq_pkg::st_hold: begin
					// a finished cycle leaves nothing to resume
					if (fault || stop_cmd) begin
						next_state.fsm = spsq_pkg::st_idle;
						next_state.saved_valid = 1'b0;
					end
				end
				default: begin
					next_state.fsm = spsq_pkg::st_idle;
				end
			endcase
		end
		// drive outputs from the state about to be entered
		if (next_state.fsm == spsq_pkg::st_idle) begin
			next_state.running = 1'b0;
			next_state.ramp_set = 2'h0;
			next_state.raw_ref = (mode == spsq_pkg::MODE_OFF && !power_fail) ? next_state.freq_cmd : '0;
		end else begin
			next_state.running = 1'b1;
			// look at the stage being entered so a new stage never shows the old set; its speed reaches speed_ref one cycle later through the conditioner
			next_state.ramp_set = setting[next_state.stage][spsq_pkg::TENS_LSB +: 2];
			if (next_state.use_saved_freq) begin
				next_state.raw_ref = next_state.saved_freq;
			end else if (setting[next_state.stage][spsq_pkg::UNITS_LSB +: 2] == spsq_pkg::SRC_EXTERNAL) begin
				next_state.raw_ref = next_state.freq_cmd;
			end else begin
				next_state.raw_ref = preset[next_state.stage];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
			state.fsm <= spsq_pkg::st_idle;
			state.boot <= 1'b1; // preset one is loaded on the first edge after release
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// reference conditioning behind the sequencer
	spsq_speed_cond #(
		.SPD_W(SPD_W),
		.SKIPS(SKIPS)
	) u_cond (
		.clk(clk),
		.reset_n(reset_n),
		.ref_in(state.raw_ref),
		.ramp_output(ramp_output),
		.motor_speed(motor_speed),
		.max_speed(max_speed),
		.deviation_clamp_enable(deviation_clamp_enable),
		.deviation_positive_limit(deviation_positive_limit),
		.deviation_negative_limit(deviation_negative_limit),
		.skip_speed_table(skip_speed_table),
		.skip_band_width(skip_band_width),
		.speed_ref(speed_ref),
		.ramp_cmd(ramp_cmd),
		.band_upper(band_upper),
		.band_lower(band_lower)
	);

	// status straight from the state register
	assign ramp_set = state.ramp_set;
	assign running = state.running;
	assign program_active = state.running; // set exactly when the machine leaves idle
	assign stage_index = state.stage;
	assign stage_elapsed = state.elapsed;
	assign cycle_done = state.cycle_done;
	assign resume_pending = state.saved_valid;
endmodule // spsq_sequencer

// ---- verilog/spsq_speed_cond.sv ----
// speed command conditioning: resonance skip bands and deviation clamp
`timescale 1ns/1ps
module spsq_speed_cond #(
	parameter int SPD_W = spsq_pkg::SPD_W,
	parameter int SKIPS = spsq_pkg::SKIPS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// speeds
	input wire logic signed [SPD_W-1:0] ref_in,
	input wire logic signed [SPD_W-1:0] ramp_output,
	input wire logic signed [SPD_W-1:0] motor_speed,
	input wire logic [SPD_W-1:0] max_speed,
	// settings
	input wire logic deviation_clamp_enable,
	input wire logic [spsq_pkg::PCT_W-1:0] deviation_positive_limit,
	input wire logic signed [spsq_pkg::PCT_W:0] deviation_negative_limit,
	input wire logic [SKIPS*SPD_W-1:0] skip_speed_table,
	input wire logic [spsq_pkg::SKIP_W_W-1:0] skip_band_width,
	// results
	output logic signed [SPD_W-1:0] speed_ref,
	output logic signed [SPD_W-1:0] ramp_cmd,
	output logic signed [SPD_W-1:0] band_upper,
	output logic signed [SPD_W-1:0] band_lower
);
	localparam int EW = SPD_W + 2;
	localparam int PW = SPD_W + spsq_pkg::PCT_W + 2;

	typedef struct packed {
		logic signed [SPD_W-1:0] speed_ref;
		logic signed [SPD_W-1:0] ramp_cmd;
		logic signed [SPD_W-1:0] band_upper;
		logic signed [SPD_W-1:0] band_lower;
	} spsq_cond_state_t;

	spsq_cond_state_t state;
	spsq_cond_state_t next_state;
	logic [SKIPS-1:0] in_band;
	logic signed [EW-1:0] band_edge [SKIPS];
	logic signed [EW-1:0] ref_x;
	logic signed [EW-1:0] half_w;
	logic signed [PW-1:0] up_p;
	logic signed [PW-1:0] dn_p;
	logic signed [EW-1:0] up_d;
	logic signed [EW-1:0] dn_d;
	logic signed [EW-1:0] lo_lim;
	logic signed [EW-1:0] hi_lim;
	logic signed [EW-1:0] ramp_x;

	assign ref_x = EW'(ref_in);
	assign half_w = EW'({1'b0, skip_band_width[spsq_pkg::SKIP_W_W-1:1]});

	// ==========================================================
	// per skip point: band test and the nearer edge
	genvar i;
	generate
		for (i = 0; i < SKIPS; i++) begin : g_skip
			logic signed [EW-1:0] centre;
			assign centre = EW'({1'b0, skip_speed_table[i*SPD_W +: SPD_W]});
			assign in_band[i] = (skip_band_width != '0) && (ref_x > centre - half_w) && (ref_x < centre + half_w);
			assign band_edge[i] = (ref_x >= centre) ? centre + half_w : centre - half_w;
		end
	endgenerate

	// band width in speed units: max speed times tenths of a percent
	assign up_p = $signed({2'b00, max_speed}) * $signed({1'b0, deviation_positive_limit});
	assign dn_p = $signed({2'b00, max_speed}) * deviation_negative_limit;
	assign up_d = EW'(up_p / spsq_pkg::PCT_FULL);
	assign dn_d = EW'(dn_p / spsq_pkg::PCT_FULL);
	assign lo_lim = EW'(motor_speed) + dn_d;
	assign hi_lim = EW'(motor_speed) + up_d;
	assign ramp_x = EW'(ramp_output);

	// lowest-numbered band wins when bands overlap
	always_comb begin
		next_state = state;
		next_state.speed_ref = ref_in;
		for (int k = SKIPS - 1; k >= 0; k--) begin
			if (in_band[k]) begin
				next_state.speed_ref = SPD_W'(band_edge[k]);
			end
		end
		if (deviation_clamp_enable) begin
			next_state.band_upper = SPD_W'(ramp_x + up_d);
			next_state.band_lower = SPD_W'(ramp_x + dn_d);
			if (ramp_x > hi_lim) begin
				next_state.ramp_cmd = SPD_W'(hi_lim);
			end else if (ramp_x < lo_lim) begin
				next_state.ramp_cmd = SPD_W'(lo_lim);
			end else begin
				next_state.ramp_cmd = ramp_output;
			end
		end else begin
			next_state.band_upper = {1'b0, {(SPD_W-1){1'b1}}};
			next_state.band_lower = {1'b1, {(SPD_W-1){1'b0}}};
			next_state.ramp_cmd = ramp_output;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign speed_ref = state.speed_ref;
	assign ramp_cmd = state.ramp_cmd;
	assign band_upper = state.band_upper;
	assign band_lower = state.band_lower;
endmodule // spsq_speed_cond

// ---- verilog/spsq_unit_tick.sv ----
// tick generator: one pulse per tenth of the selected stage time unit
`timescale 1ns/1ps
module spsq_unit_tick #(
	parameter int TENTH_CYCLES = spsq_pkg::TENTH_CYCLES,
	parameter int PRE_W = $clog2(TENTH_CYCLES + 1)
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic enable,
	input wire logic [1:0] unit_sel,
	// result
	output logic tick
);
	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [11:0] mult;
		logic tick;
	} spsq_tick_state_t;

	spsq_tick_state_t state;
	spsq_tick_state_t next_state;
	logic [11:0] mult_top;

	// ==========================================================
	// unit multiplier: a minute or hour tenth is 60 or 3600 second tenths
	always_comb begin
		case (unit_sel)
			spsq_pkg::UNIT_MIN: mult_top = 12'(spsq_pkg::SEC_PER_MIN - 1);
			spsq_pkg::UNIT_HOUR: mult_top = 12'(spsq_pkg::SEC_PER_HOUR - 1);
			default: mult_top = 12'h000; // code 3 falls back to seconds
		endcase
	end

	// counters restart whenever disabled so a stage never inherits a partial tenth
	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (!enable) begin
			next_state.pre = '0;
			next_state.mult = 12'h000;
		end else if (state.pre == PRE_W'(TENTH_CYCLES - 1)) begin
			next_state.pre = '0;
			if (state.mult >= mult_top) begin
				next_state.mult = 12'h000;
				next_state.tick = 1'b1;
			end else begin
				next_state.mult = state.mult + 12'h001;
			end
		end else begin
			next_state.pre = state.pre + PRE_W'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.tick;
endmodule // spsq_unit_tick
